// >>> hdl/opsi_device.sv
// Contract
// - Select 00 converter 1, 10 converter 2
// - Select 11 and 01 unused
// - Bit from twofold high or low dominance
// - Bit spans falling edge to falling edge
// - First byte must match device address
// - Data byte: ack request, select, value
// - Ack only if requested, matched, complete
// - Ack pulls line low for pulse time
// - Ack starts after valid delay; master holds low
// - Master releases and samples for ack
// - No ack: pull-down stays off
// - Master waits for ack end
// - Open-drain ack; open-drain master to request
// - Line high forces PWM at once
// - PWM held during frame reception
// - Long low after fall enables power save
// - Mode-change fall is taken as first bit
// - Master sends frame before entering power save; host pulls low at once on a mode write while idle
// - Mode timeout at most 520 us
// - Start hold high before each byte
// - Each byte closed by end of stream
// - Bit rates 1.7 to 160 kbit/s accepted
`default_nettype none
module opsi_device #(
  parameter int unsigned ACK_PULSE_CYC = opsi_pkg::ACK_PULSE_CYC,
  parameter int unsigned MODE_TIMEOUT_CYC = opsi_pkg::MODE_TIMEOUT_CYC,
  parameter int unsigned ACK_VALID_CYC = opsi_pkg::ACK_VALID_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  opsi_link_if.device link,
  output logic [4:0] conv1_setting,
  output logic [4:0] conv2_setting,
  output logic power_save_en,
  output logic frame_stored
);
  localparam int W = opsi_pkg::CNT_W;

  if (ACK_PULSE_CYC < 1 || ACK_PULSE_CYC >= 2 ** W ||
      MODE_TIMEOUT_CYC < 2 || MODE_TIMEOUT_CYC >= 2 ** W ||
      ACK_VALID_CYC < 1 || ACK_VALID_CYC >= 2 ** W) begin : g_bad_par
    $error("opsi_device: timing parameter out of range");
  end
  if (opsi_pkg::SLOW_BIT_CYC >= 2 ** W) begin : g_bad_w
    $error("opsi_device: counter too narrow for slowest bit");
  end

  localparam logic [W-1:0] TO_LAST = W'(MODE_TIMEOUT_CYC - 1);
  localparam logic [W-1:0] PULSE_LAST = W'(ACK_PULSE_CYC - 1);
  localparam logic [W-1:0] VALID_LAST = W'(ACK_VALID_CYC - 1);
  localparam logic [W-1:0] SAT = {W{1'b1}};

  typedef enum logic [2:0] {
    ST_IDLE, ST_LOW, ST_HIGH, ST_EOS, ST_START, ST_ACKWAIT, ST_ACKPULSE
  } opsi_dev_st_t;

  opsi_dev_st_t st_q;
  logic line_s1_q, line_s2_q, line_p_q;
  logic fall, rise, timeout;
  logic [W-1:0] to_cnt_q, lo_cnt_q, hi_cnt_q, tmr_q;
  logic [4:0] bit_cnt_q;
  logic [15:0] shift_q, shift_d;
  logic err_q, err_d, is_one, is_zero;
  logic ack_ok_q, frame_ok;
  logic [4:0] conv1_q, conv2_q;
  logic psave_q, stored_q, dev_oe_n_q;

  // ************************************************************
  // Line synchroniser and edges
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_s1_q <= 1'b1;
      line_s2_q <= 1'b1;
      line_p_q <= 1'b1;
    end else begin
      line_s1_q <= link.line;
      line_s2_q <= line_s1_q;
      line_p_q <= line_s2_q;
    end
  end
  assign fall = line_p_q && !line_s2_q;
  assign rise = !line_p_q && line_s2_q;

  // ************************************************************
  // Mode selection
  // ************************************************************
  // Own ack pulse and the master's hold before it do not count as a mode change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      to_cnt_q <= '0;
    end else if (line_s2_q || st_q == ST_ACKWAIT || st_q == ST_ACKPULSE) begin
      to_cnt_q <= '0;
    end else if (to_cnt_q != TO_LAST) begin
      to_cnt_q <= to_cnt_q + 1'b1;
    end
  end
  assign timeout = !line_s2_q && to_cnt_q == TO_LAST && st_q != ST_ACKWAIT &&
                   st_q != ST_ACKPULSE;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      psave_q <= 1'b0;
    end else if (line_s2_q) begin
      psave_q <= 1'b0;
    end else if (timeout) begin
      psave_q <= 1'b1;
    end
  end
  // A frame only leaves PWM by its own timeout, which also ends reception
  assign power_save_en = psave_q;

  // ************************************************************
  // Bit decoder
  // ************************************************************
  assign is_one = {1'b0, hi_cnt_q} >= {lo_cnt_q, 1'b0};
  assign is_zero = {1'b0, lo_cnt_q} >= {hi_cnt_q, 1'b0};
  assign shift_d = {shift_q[14:0], is_one};
  assign err_d = err_q || !(is_one || is_zero);
  // Address byte sits in the upper half after 16 bits
  assign frame_ok = !err_d && shift_d[15:8] == opsi_pkg::DEV_ADDR &&
                    {shift_d[opsi_pkg::SEL_HI_POS], shift_d[opsi_pkg::SEL_LO_POS]} !=
                    opsi_pkg::SEL_CONV1_HIGH &&
                    {shift_d[opsi_pkg::SEL_HI_POS], shift_d[opsi_pkg::SEL_LO_POS]} !=
                    2'h3;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= ST_IDLE;
      lo_cnt_q <= '0;
      hi_cnt_q <= '0;
      tmr_q <= '0;
      bit_cnt_q <= '0;
      shift_q <= '0;
      err_q <= 1'b0;
      ack_ok_q <= 1'b0;
    end else if (timeout && st_q != ST_IDLE) begin
      st_q <= ST_IDLE;
    end else begin
      case (st_q)
        ST_IDLE: begin
          // Any fall starts a bit, a mode-change fall included
          if (fall) begin
            st_q <= ST_LOW;
            lo_cnt_q <= '0;
            hi_cnt_q <= '0;
            bit_cnt_q <= '0;
            err_q <= 1'b0;
          end
        end
        ST_LOW: begin
          if (rise) begin
            st_q <= ST_HIGH;
          end else if (lo_cnt_q != SAT) begin
            lo_cnt_q <= lo_cnt_q + 1'b1;
          end
        end
        ST_HIGH: begin
          if (fall) begin
            shift_q <= shift_d;
            err_q <= err_d;
            bit_cnt_q <= bit_cnt_q + 1'b1;
            lo_cnt_q <= '0;
            hi_cnt_q <= '0;
            tmr_q <= '0;
            if (bit_cnt_q == 5'(opsi_pkg::FRAME_BITS - 1)) begin
              st_q <= ST_ACKWAIT;
              ack_ok_q <= frame_ok && shift_d[opsi_pkg::ACK_REQ_POS];
            end else if (bit_cnt_q == 5'd7) begin
              st_q <= ST_EOS;
            end else begin
              st_q <= ST_LOW;
            end
          end else if (hi_cnt_q == TO_LAST) begin
            st_q <= ST_IDLE;
          end else begin
            hi_cnt_q <= hi_cnt_q + 1'b1;
          end
        end
        ST_EOS: begin
          if (rise) begin
            st_q <= ST_START;
            hi_cnt_q <= '0;
          end
        end
        ST_START: begin
          // Stuck-high line abandons the frame so the next fall resyncs
          if (fall) begin
            st_q <= ST_LOW;
            hi_cnt_q <= '0;
          end else if (hi_cnt_q == TO_LAST) begin
            st_q <= ST_IDLE;
          end else begin
            hi_cnt_q <= hi_cnt_q + 1'b1;
          end
        end
        ST_ACKWAIT: begin
          // No ack due: leave at once, or a frame sent right after is missed
          if (!ack_ok_q) begin
            st_q <= ST_IDLE;
          end else if (tmr_q == VALID_LAST) begin
            tmr_q <= '0;
            st_q <= ack_ok_q ? ST_ACKPULSE : ST_IDLE;
          end else begin
            tmr_q <= tmr_q + 1'b1;
          end
        end
        ST_ACKPULSE: begin
          if (tmr_q == PULSE_LAST) begin
            st_q <= ST_IDLE;
          end else begin
            tmr_q <= tmr_q + 1'b1;
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ************************************************************
  // Settings
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv1_q <= opsi_pkg::CONV1_RST;
      conv2_q <= opsi_pkg::CONV2_RST;
      stored_q <= 1'b0;
    end else begin
      stored_q <= 1'b0;
      if (st_q == ST_HIGH && fall && !timeout &&
          bit_cnt_q == 5'(opsi_pkg::FRAME_BITS - 1) && frame_ok) begin
        stored_q <= 1'b1;
        // Value field is the low five bits of the data byte
        if ({shift_d[opsi_pkg::SEL_HI_POS], shift_d[opsi_pkg::SEL_LO_POS]} ==
            opsi_pkg::SEL_CONV1) begin
          conv1_q <= shift_d[opsi_pkg::VAL_W-1:0];
        end else begin
          conv2_q <= shift_d[opsi_pkg::VAL_W-1:0];
        end
      end
    end
  end
  assign conv1_setting = conv1_q;
  assign conv2_setting = conv2_q;
  assign frame_stored = stored_q;

  // ************************************************************
  // Acknowledge pull-down
  // ************************************************************
  // Pull-down only: the pin never drives high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dev_oe_n_q <= 1'b1;
    end else begin
      dev_oe_n_q <= !(st_q == ST_ACKWAIT && tmr_q == VALID_LAST && ack_ok_q &&
                      !timeout) && !(st_q == ST_ACKPULSE && tmr_q != PULSE_LAST);
    end
  end
  assign link.dev_oe_n = dev_oe_n_q;
  assign link.dev_o = 1'b0;
endmodule : opsi_device
`default_nettype wire

// >>> hdl/opsi_pkg.sv
`default_nettype none
package opsi_pkg;
  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_NS = 100;
  localparam int ACK_PULSE_US = 520;
  localparam int ACK_PULSE_CYC = ACK_PULSE_US * 1000 / CLK_NS;
  localparam int MODE_TIMEOUT_US = 520;
  localparam int MODE_TIMEOUT_CYC = MODE_TIMEOUT_US * 1000 / CLK_NS;
  localparam int ACK_VALID_US = 5;
  localparam int ACK_VALID_CYC = ACK_VALID_US * 1000 / CLK_NS;
  localparam int START_HOLD_US = 2;
  localparam int START_HOLD_CYC = (START_HOLD_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int EOS_US = 2;
  localparam int EOS_CYC = (EOS_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int BIT_US = 10;
  localparam int BIT_CYC = BIT_US * 1000 / CLK_NS;
  localparam int BIT_SHORT_CYC = BIT_CYC / 4;
  localparam int BIT_LONG_CYC = BIT_CYC - BIT_SHORT_CYC;
  // Slowest accepted bit period, 1.7 kbit/s
  localparam int SLOW_BIT_NS = 588236;
  localparam int SLOW_BIT_CYC = (SLOW_BIT_NS + CLK_NS - 1) / CLK_NS;
  // Host covers the device's input synchroniser lag
  localparam int ACK_HOLD_MARGIN = 4;
  localparam int HOST_HOLD_CYC = ACK_VALID_CYC + ACK_HOLD_MARGIN;
  localparam int ACK_SAMPLE_CYC = 8;
  localparam int CNT_W = 16;
  // ************************************************************
  // Frame layout
  // ************************************************************
  localparam logic [7:0] DEV_ADDR = 8'h4E;
  localparam int ACK_REQ_POS = 7;
  localparam int SEL_HI_POS = 6;
  localparam int SEL_LO_POS = 5;
  localparam int VAL_W = 5;
  localparam int FRAME_BITS = 16;
  localparam logic [1:0] SEL_CONV1 = 2'h0;
  localparam logic [1:0] SEL_CONV1_HIGH = 2'h1;
  localparam logic [1:0] SEL_CONV2 = 2'h2;
  localparam logic [4:0] CONV1_RST = 5'h00;
  localparam logic [4:0] CONV2_RST = 5'h00;
  // ************************************************************
  // Host register map
  // ************************************************************
  localparam logic [7:0] OFF_TX = 8'h00;
  localparam logic [7:0] OFF_MODE = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam int ST_BUSY_POS = 0;
  localparam int ST_DONE_POS = 1;
  localparam int ST_ACK_POS = 2;
  localparam logic MODE_RST = 1'b1;
endpackage : opsi_pkg
`default_nettype wire

// >>> hdl/opsi_link_if.sv
`default_nettype none
interface opsi_link_if;
  logic host_o;
  logic host_oe_n;
  logic dev_o;
  logic dev_oe_n;
  wire logic line;
  // Open-drain wire with pull-up: low if either end pulls it low
  assign line = !((!host_oe_n && !host_o) || (!dev_oe_n && !dev_o));
  modport host (output host_o, output host_oe_n, input line);
  modport device (output dev_o, output dev_oe_n, input line);
endinterface : opsi_link_if
`default_nettype wire

// >>> hdl/opsi_host.sv
`default_nettype none
module opsi_host (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  opsi_link_if.host link
);
  localparam int W = opsi_pkg::CNT_W;
  localparam logic [W-1:0] START_LAST = W'(opsi_pkg::START_HOLD_CYC - 1);
  localparam logic [W-1:0] SHORT_LAST = W'(opsi_pkg::BIT_SHORT_CYC - 1);
  localparam logic [W-1:0] LONG_LAST = W'(opsi_pkg::BIT_LONG_CYC - 1);
  localparam logic [W-1:0] EOS_LAST = W'(opsi_pkg::EOS_CYC - 1);
  localparam logic [W-1:0] HOLD_LAST = W'(opsi_pkg::HOST_HOLD_CYC - 1);
  localparam logic [W-1:0] SAMP_LAST = W'(opsi_pkg::ACK_SAMPLE_CYC - 1);

  if (opsi_pkg::HOST_HOLD_CYC < opsi_pkg::EOS_CYC ||
      opsi_pkg::BIT_SHORT_CYC < 1) begin : g_bad_par
    $error("opsi_host: timing constants out of range");
  end

  typedef enum logic [2:0] {
    HS_IDLE, HS_START, HS_LOW, HS_HIGH, HS_EOS, HS_HOLD, HS_SAMPLE, HS_ACKEND
  } opsi_host_st_t;

  opsi_host_st_t st_q;
  logic line_s1_q, line_s2_q;
  logic [W-1:0] tmr_q;
  logic [3:0] bit_cnt_q;
  logic [15:0] shift_q;
  logic [7:0] tx_q;
  logic mode_pwm_q, busy_q, done_q, ack_q, pull_q;
  logic pready_q, pslverr_q, acc, go, mapped;
  logic [31:0] prdata_q;

  // ************************************************************
  // APB slave, one wait state
  // ************************************************************
  assign acc = psel && penable && pready_q;
  assign mapped = paddr == opsi_pkg::OFF_TX || paddr == opsi_pkg::OFF_MODE ||
                  paddr == opsi_pkg::OFF_STATUS;
  // A frame request while busy is dropped rather than queued
  assign go = acc && pwrite && paddr == opsi_pkg::OFF_TX && !busy_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else begin
      pready_q <= psel && penable && !pready_q;
      pslverr_q <= psel && penable && !pready_q && !mapped;
      prdata_q <= '0;
      if (psel && penable && !pready_q && !pwrite) begin
        case (paddr)
          opsi_pkg::OFF_TX: prdata_q <= {24'h000000, tx_q};
          opsi_pkg::OFF_MODE: prdata_q <= {31'h0, mode_pwm_q};
          opsi_pkg::OFF_STATUS: begin
            prdata_q[opsi_pkg::ST_BUSY_POS] <= busy_q;
            prdata_q[opsi_pkg::ST_DONE_POS] <= done_q;
            prdata_q[opsi_pkg::ST_ACK_POS] <= ack_q;
          end
          default: prdata_q <= '0;
        endcase
      end
    end
  end
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign prdata = prdata_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_q <= '0;
      mode_pwm_q <= opsi_pkg::MODE_RST;
    end else begin
      if (go) begin
        tx_q <= pwdata[7:0];
      end
      if (acc && pwrite && paddr == opsi_pkg::OFF_MODE) begin
        mode_pwm_q <= pwdata[0];
      end
    end
  end

  // ************************************************************
  // Link master
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_s1_q <= 1'b1;
      line_s2_q <= 1'b1;
    end else begin
      line_s1_q <= link.line;
      line_s2_q <= line_s1_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= HS_IDLE;
      tmr_q <= '0;
      bit_cnt_q <= '0;
      shift_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      ack_q <= 1'b0;
    end else begin
      tmr_q <= tmr_q + 1'b1;
      case (st_q)
        HS_IDLE: begin
          if (go) begin
            st_q <= HS_START;
            tmr_q <= '0;
            bit_cnt_q <= '0;
            shift_q <= {opsi_pkg::DEV_ADDR, pwdata[7:0]};
            busy_q <= 1'b1;
            done_q <= 1'b0;
            ack_q <= 1'b0;
          end
        end
        HS_START: begin
          if (tmr_q == START_LAST) begin
            st_q <= HS_LOW;
            tmr_q <= '0;
          end
        end
        HS_LOW: begin
          if (tmr_q == (shift_q[15] ? SHORT_LAST : LONG_LAST)) begin
            st_q <= HS_HIGH;
            tmr_q <= '0;
          end
        end
        HS_HIGH: begin
          if (tmr_q == (shift_q[15] ? LONG_LAST : SHORT_LAST)) begin
            tmr_q <= '0;
            shift_q <= {shift_q[14:0], 1'b0};
            bit_cnt_q <= bit_cnt_q + 1'b1;
            st_q <= bit_cnt_q[2:0] == 3'h7 ? HS_EOS : HS_LOW;
          end
        end
        HS_EOS: begin
          if (bit_cnt_q == 4'h8 && tmr_q == EOS_LAST) begin
            st_q <= HS_START;
            tmr_q <= '0;
          end else if (bit_cnt_q == 4'h0 && tx_q[opsi_pkg::ACK_REQ_POS]) begin
            st_q <= HS_HOLD;
          end else if (bit_cnt_q == 4'h0 && tmr_q == EOS_LAST) begin
            st_q <= HS_IDLE;
            busy_q <= 1'b0;
            done_q <= 1'b1;
          end
        end
        HS_HOLD: begin
          if (tmr_q == HOLD_LAST) begin
            st_q <= HS_SAMPLE;
            tmr_q <= '0;
          end
        end
        HS_SAMPLE: begin
          if (tmr_q == SAMP_LAST) begin
            ack_q <= !line_s2_q;
            st_q <= HS_ACKEND;
          end
        end
        HS_ACKEND: begin
          if (line_s2_q) begin
            st_q <= HS_IDLE;
            busy_q <= 1'b0;
            done_q <= 1'b1;
          end
        end
        default: begin
          st_q <= HS_IDLE;
        end
      endcase
    end
  end

  // Open-drain only, so an acknowledge may always be requested
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pull_q <= 1'b0;
    end else begin
      case (st_q)
        HS_IDLE: pull_q <= !go && !mode_pwm_q;
        HS_START: pull_q <= tmr_q == START_LAST;
        HS_LOW: pull_q <= tmr_q != (shift_q[15] ? SHORT_LAST : LONG_LAST);
        HS_HIGH: pull_q <= tmr_q == (shift_q[15] ? LONG_LAST : SHORT_LAST);
        HS_EOS: pull_q <= !(bit_cnt_q == 4'h8 && tmr_q == EOS_LAST) &&
                          !(bit_cnt_q == 4'h0 && !tx_q[opsi_pkg::ACK_REQ_POS] &&
                            tmr_q == EOS_LAST && mode_pwm_q);
        HS_HOLD: pull_q <= tmr_q != HOLD_LAST;
        HS_SAMPLE: pull_q <= 1'b0;
        HS_ACKEND: pull_q <= line_s2_q && !mode_pwm_q;
        default: pull_q <= 1'b0;
      endcase
    end
  end
  assign link.host_oe_n = !pull_q;
  assign link.host_o = 1'b0;
endmodule : opsi_host
`default_nettype wire

// >>> verification/opsi_link_chk.sv
`default_nettype none
module opsi_link_chk #(
  parameter int ACK_PULSE_CYC = 100,
  parameter int ACK_VALID_CYC = 50
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic host_o,
  input wire logic host_oe_n,
  input wire logic dev_o,
  input wire logic dev_oe_n,
  input wire logic line
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] ack_cnt_q;
  logic [15:0] low_cnt_q;
  // ************************************************************
  // Run lengths of the ack pull-down and of the low line
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ack_cnt_q <= 16'h0000;
    else ack_cnt_q <= dev_oe_n ? 16'h0000 : ack_cnt_q + 16'h0001;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) low_cnt_q <= 16'h0000;
    else low_cnt_q <= line ? 16'h0000 : low_cnt_q + 16'h0001;
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_dev_open_drain: assert property (dev_o == 1'b0) else $error("device drove high");
  a_host_open_drain: assert property (host_o == 1'b0) else $error("host drove high");
  a_ack_after_hold: assert property ($fell(dev_oe_n) |-> $past(host_oe_n) == 1'b0)
    else $error("ack began while host released");
  // Device sees the last fall through its synchroniser, so a few cycles of slack
  a_ack_valid_delay: assert property ($fell(dev_oe_n) |->
    low_cnt_q >= ACK_VALID_CYC && low_cnt_q <= ACK_VALID_CYC + 6) else $error("ack delay off");
  a_ack_pulse_len: assert property ($rose(dev_oe_n) |-> ack_cnt_q == ACK_PULSE_CYC)
    else $error("ack pulse length off");
  a_ack_pulse_min: assert property ($fell(dev_oe_n) |-> (dev_oe_n == 1'b0) [*8])
    else $error("ack pulse cut short");
  a_host_release: assert property ($fell(dev_oe_n) |-> ##[0:8] host_oe_n)
    else $error("host kept holding during ack");
  a_host_quiet_ack: assert property (!dev_oe_n && $past(host_oe_n) |-> host_oe_n)
    else $error("host drove line during ack");
endmodule : opsi_link_chk
`default_nettype wire

// >>> verification/one_pin_voltage_scale_interface_test.sv
`default_nettype none
module one_pin_voltage_scale_interface_test;
  timeunit 1ns;
  timeprecision 1ns;
  // Shortened counts keep the run brief; timeout still exceeds any host low phase
  localparam int PULSE = 100;
  localparam int TMO = 300;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [4:0] conv1_setting;
  logic [4:0] conv2_setting;
  logic power_save_en;
  logic frame_stored;
  int err_count = 0;
  int total_checks = 0;
  int seed = 32'h1aa3;
  int n;
  logic [9:0] exp_q[$];
  logic [4:0] exp1 = 5'h00;
  logic [4:0] exp2 = 5'h00;
  logic [31:0] rd;
  logic [7:0] r;
  logic slv;
  logic in_frame = 1'b0;
  opsi_link_if link ();
  opsi_host opsi_host_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link));
  opsi_device #(.ACK_PULSE_CYC(PULSE), .MODE_TIMEOUT_CYC(TMO),
    .ACK_VALID_CYC(opsi_pkg::ACK_VALID_CYC)) opsi_device_i (.pclk(pclk), .presetn(presetn),
    .link(link), .conv1_setting(conv1_setting), .conv2_setting(conv2_setting),
    .power_save_en(power_save_en), .frame_stored(frame_stored));
  opsi_link_chk #(.ACK_PULSE_CYC(PULSE), .ACK_VALID_CYC(opsi_pkg::ACK_VALID_CYC))
    opsi_link_chk_i (.pclk(pclk), .presetn(presetn), .host_o(link.host_o),
    .host_oe_n(link.host_oe_n), .dev_o(link.dev_o), .dev_oe_n(link.dev_oe_n), .line(link.line));
  always #50 pclk = ~pclk;
  // ************************************************************
  // Compare and report
  // ************************************************************
  task stop_test;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test
  task chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_word
  task chk_set(input logic [9:0] exp, input logic [9:0] got);
    chk_word("settings", {22'h0, exp}, {22'h0, got});
  endtask : chk_set
  // ************************************************************
  // Bus and frame tasks
  // ************************************************************
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      chk_word("pready", 32'h1, 32'h0);
      stop_test;
    end
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wait_done;
    int k;
    k = 0;
    do begin
      apb(1'b0, opsi_pkg::OFF_STATUS, 32'h0);
      k++;
    end while (rd[1:0] !== 2'b10 && k < 2000);
    if (k >= 2000) begin
      chk_word("frame done", 32'h1, 32'h0);
      stop_test;
    end
  endtask : wait_done
  task note(input logic [7:0] b);
    if (b[6:5] == opsi_pkg::SEL_CONV1) exp1 = b[4:0];
    else exp2 = b[4:0];
    exp_q.push_back({exp1, exp2});
  endtask : note
  task send(input logic [7:0] b, input logic ok);
    if (ok) note(b);
    apb(1'b1, opsi_pkg::OFF_TX, {24'h0, b});
    wait_done;
    chk_word("ack seen", {31'h0, ok & b[7]}, {31'h0, rd[opsi_pkg::ST_ACK_POS]});
  endtask : send
  task wait_ps(input logic lvl, input int lim);
    n = 0;
    while (power_save_en !== lvl && n < lim) begin
      @(posedge pclk);
      n++;
    end
    if (power_save_en !== lvl) begin
      chk_word("power save wait", {31'h0, lvl}, {31'h0, power_save_en});
      stop_test;
    end
  endtask : wait_ps
  // Takes the oldest expected setting pair whenever a store appears
  always @(posedge pclk) begin
    if (presetn === 1'b1 && frame_stored === 1'b1) begin
      if (exp_q.size() == 0) chk_word("unexpected store", 32'h0, 32'h1);
      else chk_set(exp_q.pop_front(), {conv1_setting, conv2_setting});
    end
    if (in_frame && power_save_en !== 1'b0) chk_word("pwm in frame", 32'h0, 32'h1);
  end
  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    chk_set({opsi_pkg::CONV1_RST, opsi_pkg::CONV2_RST}, {conv1_setting, conv2_setting});
    apb(1'b0, opsi_pkg::OFF_MODE, 32'h0);
    chk_word("mode reset", {31'h0, opsi_pkg::MODE_RST}, {31'h0, rd[0]});
    chk_word("mode error", 32'h0, {31'h0, slv});
    apb(1'b0, opsi_pkg::OFF_STATUS, 32'h0);
    chk_word("status reset", 32'h0, rd);
    apb(1'b0, 8'h0C, 32'h0);
    chk_word("unmapped error", 32'h1, {31'h0, slv});
    chk_word("unmapped data", 32'h0, rd);
    in_frame = 1'b1;
    for (int i = 0; i < 6; i++) begin
      r = 8'($random(seed));
      send({r[7], (i[0] ? opsi_pkg::SEL_CONV2 : opsi_pkg::SEL_CONV1), r[4:0]}, 1'b1);
    end
    send({1'b1, 2'b01, 5'h15}, 1'b0);
    send({1'b1, 2'b11, 5'h0A}, 1'b0);
    // Second write lands while busy and must be dropped
    note(8'h9F);
    apb(1'b1, opsi_pkg::OFF_TX, 32'h0000009F);
    apb(1'b1, opsi_pkg::OFF_TX, 32'h000000C3);
    wait_done;
    apb(1'b0, opsi_pkg::OFF_TX, 32'h0);
    chk_word("tx kept", 32'h0000009F, rd);
    in_frame = 1'b0;
    apb(1'b1, opsi_pkg::OFF_MODE, 32'h0);
    wait_ps(1'b1, TMO + 50);
    chk_word("ps delay", 32'h1, {31'h0, n >= TMO && n <= TMO + 8});
    apb(1'b1, opsi_pkg::OFF_MODE, 32'h1);
    wait_ps(1'b0, 8);
    chk_word("pwm entry", 32'h1, {31'h0, n < 8});
    // Frame right after a mode fall is taken as shifted bits and lost
    apb(1'b1, opsi_pkg::OFF_MODE, 32'h0);
    send({1'b0, opsi_pkg::SEL_CONV1, 5'h1B}, 1'b0);
    wait_ps(1'b1, TMO + 50);
    chk_word("ps after frame", 32'h1, {31'h0, power_save_en});
    apb(1'b1, opsi_pkg::OFF_MODE, 32'h1);
    repeat (10) @(posedge pclk);
    chk_word("pending stores", 32'h0, exp_q.size());
    stop_test;
  end
endmodule : one_pin_voltage_scale_interface_test
`default_nettype wire
